// ===== trm_pkg.sv
// constants for the tone, ringing and metering oscillator control block
package trm_pkg;
  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned IDX_W             = 10;
  localparam logic [9:0]  IDX_TONE_B_CTRL   = 10'h021;
  localparam logic [9:0]  IDX_RING_CTRL     = 10'h022;
  localparam logic [9:0]  IDX_METER_CTRL    = 10'h023;
  localparam logic [9:0]  IDX_TONE_A_ON_LO  = 10'h024;
  localparam logic [9:0]  IDX_TONE_A_ON_HI  = 10'h025;
  localparam logic [9:0]  IDX_RING_RUN      = 10'h040;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_ACTIVE        = 7;
  localparam int unsigned BIT_ZC_STOP       = 5;
  localparam int unsigned BIT_ON_LINE       = 5;
  localparam int unsigned BIT_ON_TIMER      = 4;
  localparam int unsigned BIT_OFF_TIMER     = 3;
  localparam int unsigned BIT_ENABLE        = 2;
  localparam int unsigned BIT_DC_OFFSET     = 1;
  localparam int unsigned BIT_WAVE_SHAPE    = 0;
  localparam int unsigned BIT_ROUTE_TX      = 0;
  localparam int unsigned BIT_ROUTE_RX      = 1;
  localparam int unsigned BIT_RING_RUN      = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_TONE_B_CTRL   = 8'h00;
  localparam logic [7:0]  RST_RING_CTRL     = 8'h00;
  localparam logic [7:0]  RST_METER_CTRL    = 8'h00;
  localparam logic [7:0]  RST_TONE_A_ON     = 8'h00;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_NS          = 50;
  localparam int unsigned TICK_US           = 125;
  localparam int unsigned TICK_CYCLES       = (TICK_US * 1000) / CLOCK_NS;
  localparam int unsigned TICK_W            = 12;
  localparam int unsigned GEN_COUNT         = 3;
  localparam int unsigned GEN_TONE_B        = 0;
  localparam int unsigned GEN_RING          = 1;
  localparam int unsigned GEN_METER         = 2;
endpackage

// ===== trm_cad_if.sv
// carrier between the register bank and one cadence sequencer
interface trm_cad_if;
  logic        tick;
  logic        enable;
  logic        on_timer_en;
  logic        off_timer_en;
  logic        zc_stop;
  logic        zero_cross;
  logic [15:0] on_count;
  logic [15:0] off_count;
  logic        active;

  modport ctl (output tick, output enable, output on_timer_en, output off_timer_en, output zc_stop,
               output zero_cross, output on_count, output off_count, input active);
  modport gen (input tick, input enable, input on_timer_en, input off_timer_en, input zc_stop,
               input zero_cross, input on_count, input off_count, output active);
endinterface

// ===== trm_cadence.sv
// active/inactive cadence sequencer for one signal generator
module trm_cadence (
  input  wire logic i_clock,
  input  wire logic i_srst,
  trm_cad_if.gen    cad
);
  typedef enum logic [1:0] {TRM_IDLE, TRM_ON, TRM_WAIT_ZC, TRM_OFF} trm_cad_state_e;

  trm_cad_state_e state_reg;
  trm_cad_state_e state_next;
  logic [15:0]    count_reg;
  logic [15:0]    count_next;
  logic           active_reg;
  logic           active_next;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      TRM_IDLE: begin
        if (cad.enable) begin
          state_next = TRM_ON;
          count_next = cad.on_count;
        end
      end
      TRM_ON: begin
        // a disabled active timer leaves the tone on indefinitely
        if (cad.on_timer_en && cad.tick) begin
          if (count_reg <= 16'h0001) begin
            if (cad.zc_stop) begin
              state_next = TRM_WAIT_ZC;
            end else begin
              state_next = TRM_OFF;
              count_next = cad.off_count;
            end
          end else begin
            count_next = count_reg - 16'h0001;
          end
        end
      end
      TRM_WAIT_ZC: begin
        if (cad.zero_cross) begin
          state_next = TRM_OFF;
          count_next = cad.off_count;
        end
      end
      TRM_OFF: begin
        // a disabled inactive timer makes the burst a one-shot
        if (cad.off_timer_en && cad.tick) begin
          if (count_reg <= 16'h0001) begin
            state_next = TRM_ON;
            count_next = cad.on_count;
          end else begin
            count_next = count_reg - 16'h0001;
          end
        end
      end
      default: begin
        state_next = TRM_IDLE;
      end
    endcase
    if (!cad.enable) begin
      state_next = TRM_IDLE;
    end
    active_next = (state_next == TRM_ON) || (state_next == TRM_WAIT_ZC);
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg  <= TRM_IDLE;
      count_reg  <= 16'h0000;
      active_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      count_reg  <= count_next;
      active_reg <= active_next;
    end
  end

  assign cad.active = active_reg;
endmodule

// ===== trm_osc_ctrl.sv
// axi4-lite register bank and cadence control for tone, ringing and metering oscillators

module trm_osc_ctrl #(
  parameter logic [15:0] TONE_B_ON_TICKS  = 16'h0320,
  parameter logic [15:0] TONE_B_OFF_TICKS = 16'h0320,
  parameter logic [15:0] RING_ON_TICKS    = 16'h3e80,
  parameter logic [15:0] RING_OFF_TICKS   = 16'h7d00,
  parameter logic [15:0] METER_ON_TICKS   = 16'h0640,
  parameter logic [15:0] METER_OFF_TICKS  = 16'h0640
) (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic [11:0] i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [11:0] i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  input  wire logic        i_tone_b_zero_cross,
  input  wire logic        i_ring_dc_join,
  output logic             o_tone_b_tx_en,
  output logic             o_tone_b_rx_en,
  output logic             o_ring_on_line,
  output logic             o_ring_dc_offset_en,
  output logic             o_ring_wave_shape_sel,
  output logic             o_meter_active,
  output logic [15:0]      o_tone_a_on_time
);
  // ----------------------------------------------------------------
  // pin synchronisers: three stages, a change counts once two agree
  // ----------------------------------------------------------------
  logic [1:0] pin_in;
  logic [2:0] sync_reg [2];
  logic [2:0] sync_next [2];
  logic [1:0] pin_reg;
  logic [1:0] pin_next;

  assign pin_in = {i_ring_dc_join, i_tone_b_zero_cross};

  generate
    for (genvar p = 0; p < 2; p++) begin : g_sync
      always_comb begin
        sync_next[p] = {sync_reg[p][1:0], pin_in[p]};
        pin_next[p]  = (sync_reg[p][1] == sync_reg[p][2]) ? sync_reg[p][2] : pin_reg[p];
      end
      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          sync_reg[p] <= 3'h0;
          pin_reg[p]  <= 1'b0;
        end else begin
          sync_reg[p] <= sync_next[p];
          pin_reg[p]  <= pin_next[p];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // 125 us cadence tick
  // ----------------------------------------------------------------
  localparam logic [11:0] TICK_LAST = 12'(trm_pkg::TICK_CYCLES - 1);

  logic [11:0] tick_cnt_reg;
  logic [11:0] tick_cnt_next;
  logic        tick_reg;
  logic        tick_next;

  always_comb begin
    tick_next     = (tick_cnt_reg == TICK_LAST);
    tick_cnt_next = tick_next ? 12'h000 : tick_cnt_reg + 12'h001;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tick_cnt_reg <= 12'h000;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // ----------------------------------------------------------------
  // control registers and bus slave
  // ----------------------------------------------------------------
  logic [7:0]  tone_b_ctrl_reg;
  logic [7:0]  tone_b_ctrl_next;
  logic [7:0]  ring_ctrl_reg;
  logic [7:0]  ring_ctrl_next;
  logic [7:0]  meter_ctrl_reg;
  logic [7:0]  meter_ctrl_next;
  logic [7:0]  tone_a_lo_reg;
  logic [7:0]  tone_a_lo_next;
  logic [7:0]  tone_a_hi_reg;
  logic [7:0]  tone_a_hi_next;
  logic        ring_run_reg;
  logic        ring_run_next;

  logic        aw_held_reg;
  logic        aw_held_next;
  logic [9:0]  aw_idx_reg;
  logic [9:0]  aw_idx_next;
  logic        w_held_reg;
  logic        w_held_next;
  logic [7:0]  w_byte_reg;
  logic [7:0]  w_byte_next;
  logic        w_lane_reg;
  logic        w_lane_next;
  logic        awready_reg;
  logic        awready_next;
  logic        wready_reg;
  logic        wready_next;
  logic        bvalid_reg;
  logic        bvalid_next;
  logic [1:0]  bresp_reg;
  logic [1:0]  bresp_next;
  logic        arready_reg;
  logic        arready_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [1:0]  rresp_reg;
  logic [1:0]  rresp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic [2:0]  gen_active;
  logic        ring_line_reg;
  logic        ring_line_next;
  logic [9:0]  ar_idx;
  logic        do_write;
  logic        wr_lane;

  assign ar_idx  = i_s_axi_araddr[11:2];
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_lane  = do_write && w_lane_reg;

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_idx_next  = aw_idx_reg;
    w_held_next  = w_held_reg;
    w_byte_next  = w_byte_reg;
    w_lane_next  = w_lane_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    // address and data are taken in either order and held until both are in
    if (i_s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      aw_idx_next  = i_s_axi_awaddr[11:2];
    end
    if (i_s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      w_byte_next = i_s_axi_wdata[7:0];
      w_lane_next = i_s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      case (aw_idx_reg)
        trm_pkg::IDX_TONE_B_CTRL, trm_pkg::IDX_RING_CTRL, trm_pkg::IDX_METER_CTRL,
        trm_pkg::IDX_TONE_A_ON_LO, trm_pkg::IDX_TONE_A_ON_HI, trm_pkg::IDX_RING_RUN: begin
          bresp_next = trm_pkg::RESP_OKAY;
        end
        default: begin
          bresp_next = trm_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_reg && i_s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next  = !w_held_next && !bvalid_next;

    // read-only bits are masked out of the stored copy
    tone_b_ctrl_next = tone_b_ctrl_reg;
    ring_ctrl_next   = ring_ctrl_reg;
    meter_ctrl_next  = meter_ctrl_reg;
    tone_a_lo_next   = tone_a_lo_reg;
    tone_a_hi_next   = tone_a_hi_reg;
    ring_run_next    = ring_run_reg;
    if (wr_lane) begin
      case (aw_idx_reg)
        trm_pkg::IDX_TONE_B_CTRL:  tone_b_ctrl_next = w_byte_reg & 8'h3f;
        trm_pkg::IDX_RING_CTRL:    ring_ctrl_next   = w_byte_reg & 8'h1b;
        trm_pkg::IDX_METER_CTRL:   meter_ctrl_next  = w_byte_reg & 8'h1c;
        trm_pkg::IDX_TONE_A_ON_LO: tone_a_lo_next   = w_byte_reg;
        trm_pkg::IDX_TONE_A_ON_HI: tone_a_hi_next   = w_byte_reg;
        trm_pkg::IDX_RING_RUN:     ring_run_next    = w_byte_reg[trm_pkg::BIT_RING_RUN];
        default: begin
        end
      endcase
    end

    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (i_s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = trm_pkg::RESP_OKAY;
      case (ar_idx)
        trm_pkg::IDX_TONE_B_CTRL: begin
          rdata_next = {24'h000000, gen_active[trm_pkg::GEN_TONE_B], tone_b_ctrl_reg[6:0]};
        end
        trm_pkg::IDX_RING_CTRL: begin
          rdata_next = {24'h000000, gen_active[trm_pkg::GEN_RING], 1'b0, ring_line_reg,
                        ring_ctrl_reg[4:3], ring_run_reg, ring_ctrl_reg[1:0]};
        end
        trm_pkg::IDX_METER_CTRL: begin
          rdata_next = {24'h000000, gen_active[trm_pkg::GEN_METER], meter_ctrl_reg[6:0]};
        end
        trm_pkg::IDX_TONE_A_ON_LO: rdata_next = {24'h000000, tone_a_lo_reg};
        trm_pkg::IDX_TONE_A_ON_HI: rdata_next = {24'h000000, tone_a_hi_reg};
        trm_pkg::IDX_RING_RUN:     rdata_next = {31'h00000000, ring_run_reg};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = trm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && i_s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      aw_held_reg     <= 1'b0;
      aw_idx_reg      <= 10'h000;
      w_held_reg      <= 1'b0;
      w_byte_reg      <= 8'h00;
      w_lane_reg      <= 1'b0;
      awready_reg     <= 1'b0;
      wready_reg      <= 1'b0;
      bvalid_reg      <= 1'b0;
      bresp_reg       <= trm_pkg::RESP_OKAY;
      arready_reg     <= 1'b0;
      rvalid_reg      <= 1'b0;
      rresp_reg       <= trm_pkg::RESP_OKAY;
      rdata_reg       <= 32'h00000000;
      tone_b_ctrl_reg <= trm_pkg::RST_TONE_B_CTRL;
      ring_ctrl_reg   <= trm_pkg::RST_RING_CTRL;
      meter_ctrl_reg  <= trm_pkg::RST_METER_CTRL;
      tone_a_lo_reg   <= trm_pkg::RST_TONE_A_ON;
      tone_a_hi_reg   <= trm_pkg::RST_TONE_A_ON;
      ring_run_reg    <= 1'b0;
    end else begin
      aw_held_reg     <= aw_held_next;
      aw_idx_reg      <= aw_idx_next;
      w_held_reg      <= w_held_next;
      w_byte_reg      <= w_byte_next;
      w_lane_reg      <= w_lane_next;
      awready_reg     <= awready_next;
      wready_reg      <= wready_next;
      bvalid_reg      <= bvalid_next;
      bresp_reg       <= bresp_next;
      arready_reg     <= arready_next;
      rvalid_reg      <= rvalid_next;
      rresp_reg       <= rresp_next;
      rdata_reg       <= rdata_next;
      tone_b_ctrl_reg <= tone_b_ctrl_next;
      ring_ctrl_reg   <= ring_ctrl_next;
      meter_ctrl_reg  <= meter_ctrl_next;
      tone_a_lo_reg   <= tone_a_lo_next;
      tone_a_hi_reg   <= tone_a_hi_next;
      ring_run_reg    <= ring_run_next;
    end
  end

  // ----------------------------------------------------------------
  // cadence sequencers, one per generator
  // ----------------------------------------------------------------
  logic [2:0]  gen_en;
  logic [2:0]  gen_on_en;
  logic [2:0]  gen_off_en;
  logic [2:0]  gen_zc_stop;
  logic [2:0]  gen_zc;
  logic [15:0] gen_on_cnt  [3];
  logic [15:0] gen_off_cnt [3];

  always_comb begin
    gen_en      = {meter_ctrl_reg[trm_pkg::BIT_ENABLE], ring_run_reg, tone_b_ctrl_reg[trm_pkg::BIT_ENABLE]};
    gen_on_en   = {meter_ctrl_reg[trm_pkg::BIT_ON_TIMER], ring_ctrl_reg[trm_pkg::BIT_ON_TIMER],
                   tone_b_ctrl_reg[trm_pkg::BIT_ON_TIMER]};
    gen_off_en  = {meter_ctrl_reg[trm_pkg::BIT_OFF_TIMER], ring_ctrl_reg[trm_pkg::BIT_OFF_TIMER],
                   tone_b_ctrl_reg[trm_pkg::BIT_OFF_TIMER]};
    // only tone b has a zero-crossing stop
    gen_zc_stop = {2'b00, tone_b_ctrl_reg[trm_pkg::BIT_ZC_STOP]};
    gen_zc      = {2'b00, pin_reg[0]};
    gen_on_cnt[0]  = TONE_B_ON_TICKS;
    gen_off_cnt[0] = TONE_B_OFF_TICKS;
    gen_on_cnt[1]  = RING_ON_TICKS;
    gen_off_cnt[1] = RING_OFF_TICKS;
    gen_on_cnt[2]  = METER_ON_TICKS;
    gen_off_cnt[2] = METER_OFF_TICKS;
  end

  generate
    for (genvar g = 0; g < trm_pkg::GEN_COUNT; g++) begin : g_gen
      trm_cad_if cad ();
      assign cad.tick         = tick_reg;
      assign cad.enable       = gen_en[g];
      assign cad.on_timer_en  = gen_on_en[g];
      assign cad.off_timer_en = gen_off_en[g];
      assign cad.zc_stop      = gen_zc_stop[g];
      assign cad.zero_cross   = gen_zc[g];
      assign cad.on_count     = gen_on_cnt[g];
      assign cad.off_count    = gen_off_cnt[g];
      assign gen_active[g]    = cad.active;
      trm_cadence u_cadence (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .cad     (cad)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // line-side outputs
  // ----------------------------------------------------------------
  logic        tx_en_reg;
  logic        tx_en_next;
  logic        rx_en_reg;
  logic        rx_en_next;
  logic        meter_reg;
  logic        meter_next;

  always_comb begin
    tx_en_next = gen_active[trm_pkg::GEN_TONE_B] && tone_b_ctrl_reg[trm_pkg::BIT_ROUTE_TX];
    rx_en_next = gen_active[trm_pkg::GEN_TONE_B] && tone_b_ctrl_reg[trm_pkg::BIT_ROUTE_RX];
    meter_next = gen_active[trm_pkg::GEN_METER];
    // the line only follows the oscillator at the dc feed join point,
    // so no step appears on the conductors at start or stop
    ring_line_next = ring_line_reg;
    if (pin_reg[1]) begin
      ring_line_next = gen_active[trm_pkg::GEN_RING];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tx_en_reg     <= 1'b0;
      rx_en_reg     <= 1'b0;
      meter_reg     <= 1'b0;
      ring_line_reg <= 1'b0;
    end else begin
      tx_en_reg     <= tx_en_next;
      rx_en_reg     <= rx_en_next;
      meter_reg     <= meter_next;
      ring_line_reg <= ring_line_next;
    end
  end

  assign o_s_axi_awready       = awready_reg;
  assign o_s_axi_wready        = wready_reg;
  assign o_s_axi_bvalid        = bvalid_reg;
  assign o_s_axi_bresp         = bresp_reg;
  assign o_s_axi_arready       = arready_reg;
  assign o_s_axi_rvalid        = rvalid_reg;
  assign o_s_axi_rresp         = rresp_reg;
  assign o_s_axi_rdata         = rdata_reg;
  assign o_tone_b_tx_en        = tx_en_reg;
  assign o_tone_b_rx_en        = rx_en_reg;
  assign o_ring_on_line        = ring_line_reg;
  assign o_ring_dc_offset_en   = ring_ctrl_reg[trm_pkg::BIT_DC_OFFSET];
  assign o_ring_wave_shape_sel = ring_ctrl_reg[trm_pkg::BIT_WAVE_SHAPE];
  assign o_meter_active        = meter_reg;
  assign o_tone_a_on_time      = {tone_a_hi_reg, tone_a_lo_reg};
endmodule

// ===== trm_osc_ctrl_props.sv
// bus and status checks for the oscillator control register bank
module trm_osc_ctrl_props (
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic        i_ring_dc_join,
  input wire logic        o_ring_on_line,
  input wire logic [15:0] o_tone_a_on_time
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  b_done_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid ##1 o_s_axi_awready && o_s_axi_wready)
    else $error("write slot not reopened");
  r_done_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid ##1 o_s_axi_arready)
    else $error("read slot not reopened");
  r_upper_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0) else $error("rdata high bits set");
  w_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |-> ##2 o_s_axi_bvalid)
    else $error("write response late");
  ar_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("read data late");
  b_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready) else $error("write taken early");
  r_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready) else $error("read taken early");
  line_hold_a: assert property (!i_ring_dc_join [*5] |=> $stable(o_ring_on_line))
    else $error("ring line flag moved off join");
  time_write_a: assert property (!$past(i_srst) && $changed(o_tone_a_on_time) |-> o_s_axi_bvalid)
    else $error("timer changed without write");
endmodule
bind trm_osc_ctrl trm_osc_ctrl_props u_trm_osc_ctrl_props (.i_clock, .i_srst, .i_s_axi_awvalid, .o_s_axi_awready,
  .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready,
  .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready, .i_ring_dc_join, .o_ring_on_line, .o_tone_a_on_time);

// ===== tb_trm_osc_ctrl.sv
// self-checking bench for the oscillator control register bank
module tb_trm_osc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clock = 1'b0, i_srst = 1'b1, i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0;
  logic        i_s_axi_bready = 1'b0, i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic        i_tone_b_zero_cross = 1'b0, i_ring_dc_join = 1'b0;
  logic [11:0] i_s_axi_awaddr = 12'h000, i_s_axi_araddr = 12'h000;
  logic [31:0] i_s_axi_wdata = 32'h0;
  logic [3:0]  i_s_axi_wstrb = 4'hf;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic [31:0] o_s_axi_rdata;
  logic        o_tone_b_tx_en, o_tone_b_rx_en, o_ring_on_line, o_ring_dc_offset_en, o_ring_wave_shape_sel;
  logic        o_meter_active;
  logic [15:0] o_tone_a_on_time;
  int          errors = 0, check_count = 0, n;

  // a short tone b active period and short metering periods keep the cadence runs within a few thousand cycles
  trm_osc_ctrl #(
    .TONE_B_ON_TICKS (16'h0001),
    .METER_ON_TICKS  (16'h0002),
    .METER_OFF_TICKS (16'h0002)
  ) u_trm_osc_ctrl (
    .i_clock               (i_clock),
    .i_srst                (i_srst),
    .i_s_axi_awaddr        (i_s_axi_awaddr),
    .i_s_axi_awvalid       (i_s_axi_awvalid),
    .o_s_axi_awready       (o_s_axi_awready),
    .i_s_axi_wdata         (i_s_axi_wdata),
    .i_s_axi_wstrb         (i_s_axi_wstrb),
    .i_s_axi_wvalid        (i_s_axi_wvalid),
    .o_s_axi_wready        (o_s_axi_wready),
    .o_s_axi_bresp         (o_s_axi_bresp),
    .o_s_axi_bvalid        (o_s_axi_bvalid),
    .i_s_axi_bready        (i_s_axi_bready),
    .i_s_axi_araddr        (i_s_axi_araddr),
    .i_s_axi_arvalid       (i_s_axi_arvalid),
    .o_s_axi_arready       (o_s_axi_arready),
    .o_s_axi_rdata         (o_s_axi_rdata),
    .o_s_axi_rresp         (o_s_axi_rresp),
    .o_s_axi_rvalid        (o_s_axi_rvalid),
    .i_s_axi_rready        (i_s_axi_rready),
    .i_tone_b_zero_cross   (i_tone_b_zero_cross),
    .i_ring_dc_join        (i_ring_dc_join),
    .o_tone_b_tx_en        (o_tone_b_tx_en),
    .o_tone_b_rx_en        (o_tone_b_rx_en),
    .o_ring_on_line        (o_ring_on_line),
    .o_ring_dc_offset_en   (o_ring_dc_offset_en),
    .o_ring_wave_shape_sel (o_ring_wave_shape_sel),
    .o_meter_active        (o_meter_active),
    .o_tone_a_on_time      (o_tone_a_on_time)
  );

  initial begin
    forever #25 i_clock = ~i_clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // each channel drops its valid at the edge where its ready is seen
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge i_clock);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= {24'h0, d};
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      i_s_axi_awvalid <= i_s_axi_awvalid & ~o_s_axi_awready;
      i_s_axi_wvalid <= i_s_axi_wvalid & ~o_s_axi_wready;
    end while (!o_s_axi_bvalid);
    i_s_axi_bready <= 1'b0;
    chk({30'h0, o_s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge i_clock);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      i_s_axi_arvalid <= i_s_axi_arvalid & ~o_s_axi_arready;
    end while (!o_s_axi_rvalid);
    i_s_axi_rready <= 1'b0;
    chk(o_s_axi_rdata, {24'h0, d});
    chk({30'h0, o_s_axi_rresp}, {30'h0, er});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge i_clock);
    errors++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_srst <= 1'b0;
    rd(12'h08c, 8'h00, 2'h0);
    wr(12'h090, 8'ha5, 2'h0);
    wr(12'h094, 8'h3c, 2'h0);
    rd(12'h090, 8'ha5, 2'h0);
    chk({16'h0, o_tone_a_on_time}, 32'h3ca5);
    wr(12'h200, 8'h55, 2'h2);
    $display("test timer bytes done");
    wr(12'h084, 8'hff, 2'h0);
    rd(12'h084, 8'hbf, 2'h0);
    for (int r = 0; r < 4; r++) begin
      wr(12'h084, 8'h04 | 8'(r), 2'h0);
      rd(12'h084, 8'h84 | 8'(r), 2'h0);
      chk({30'h0, o_tone_b_rx_en, o_tone_b_tx_en}, 32'(r));
    end
    wr(12'h084, 8'h03, 2'h0);
    rd(12'h084, 8'h03, 2'h0);
    wr(12'h084, 8'h14, 2'h0);
    rd(12'h084, 8'h94, 2'h0);
    // one tick ends the single-count active period
    repeat (2600) @(posedge i_clock);
    rd(12'h084, 8'h14, 2'h0);
    wr(12'h084, 8'h00, 2'h0);
    wr(12'h084, 8'h34, 2'h0);
    repeat (2600) @(posedge i_clock);
    rd(12'h084, 8'hb4, 2'h0);
    i_tone_b_zero_cross <= 1'b1;
    // the pin needs its synchroniser stages before the stop shows
    repeat (8) @(posedge i_clock);
    rd(12'h084, 8'h34, 2'h0);
    i_tone_b_zero_cross <= 1'b0;
    $display("test tone b done");
    wr(12'h088, 8'hff, 2'h0);
    rd(12'h088, 8'h1b, 2'h0);
    wr(12'h100, 8'h01, 2'h0);
    rd(12'h200, 8'h00, 2'h2);
    rd(12'h088, 8'h9f, 2'h0);
    chk({29'h0, o_ring_on_line, o_ring_dc_offset_en, o_ring_wave_shape_sel}, 32'h3);
    i_ring_dc_join <= 1'b1;
    // synchroniser plus line flag take five edges to follow the pin
    repeat (4) @(posedge i_clock);
    rd(12'h200, 8'h00, 2'h2);
    rd(12'h088, 8'hbf, 2'h0);
    chk({31'h0, o_ring_on_line}, 32'h1);
    wr(12'h088, 8'h18, 2'h0);
    chk({30'h0, o_ring_dc_offset_en, o_ring_wave_shape_sel}, 32'h0);
    $display("test ringing done");
    wr(12'h08c, 8'hff, 2'h0);
    rd(12'h08c, 8'h9c, 2'h0);
    chk({31'h0, o_meter_active}, 32'h1);
    while (o_meter_active === 1'b1) @(posedge i_clock);
    n = 0;
    while (o_meter_active !== 1'b1) begin
      @(posedge i_clock);
      n++;
    end
    chk(32'(n), 32'd5000);
    $display("test metering done");
    finish_test();
  end
endmodule
